// *** hw/qps_sequencer.sv ***
// Quad-phase clock generator and two-stage fetch/execute sequencer
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

//Contract
// - Oscillator clock divided by four into non-overlapping phases a to d.
// - One instruction cycle is phase_a, phase_b, phase_c, phase_d in order.
// - Program counter increments in phase_a, starting the next fetch.
// - Fetched program word is captured by phase_d of its fetch cycle.
// - Instruction latch loads in phase_a; decode and execute in b to d.
// - Fetch of next overlaps execute of current: one instruction per cycle.
// - A program counter change takes two instruction cycles.
// - Data read happens in phase_b, data write in phase_d.
// - In RC mode cycle_clock_out runs at one quarter oscillator rate.
// - Active-low master clear resets the device.
// - Instructions are 14 bits, data 8 bits, on separate buses.
// - Eight-entry hardware return-address stack for calls.
// - Program counter is 13 bits and cleared on every reset.
// - Stack wraps circularly; ninth push overwrites oldest, no flags.
module qps_sequencer #(
   parameter int DADDR_W = `QPS_DADDR_W
) (
   input  wire logic                      mclk_in,
   input  wire logic                      resetn_in,
   input  wire logic                      master_clear_n_in,
   input  wire logic                      rc_mode_in,
   output logic                           phase_a_out,
   output logic                           phase_b_out,
   output logic                           phase_c_out,
   output logic                           phase_d_out,
   output logic                           cycle_clock_out,
   output logic [`QPS_PC_W-1:0]           prog_addr_out,
   output logic                           prog_rd_out,
   input  wire logic [`QPS_INSTR_W-1:0]   prog_data_in,
   output logic [`QPS_INSTR_W-1:0]        instruction_latch_out,
   output logic                           exec_valid_out,
   input  wire logic                      exec_jump_in,
   input  wire logic                      exec_call_in,
   input  wire logic                      exec_return_in,
   input  wire logic [`QPS_PC_W-1:0]      exec_target_in,
   input  wire logic                      exec_rd_in,
   input  wire logic                      exec_wr_in,
   input  wire logic [DADDR_W-1:0]        exec_addr_in,
   input  wire logic [`QPS_DATA_W-1:0]    exec_wdata_in,
   output logic [DADDR_W-1:0]             data_addr_out,
   output logic                           data_rd_out,
   output logic                           data_wr_out,
   output logic [`QPS_DATA_W-1:0]         data_wdata_out,
   input  wire logic [`QPS_DATA_W-1:0]    data_rdata_in,
   output logic [`QPS_DATA_W-1:0]         operand_out
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic                      clr_meta_reg;
   logic                      clr_sync_reg;
   logic                      rc_meta_reg;
   logic                      rc_sync_reg;
   logic                      core_clear;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clr_meta_reg <= 1'b0;
         clr_sync_reg <= 1'b0;
         rc_meta_reg  <= 1'b0;
         rc_sync_reg  <= 1'b0;
      end else begin
         clr_meta_reg <= master_clear_n_in;
         clr_sync_reg <= clr_meta_reg;
         rc_meta_reg  <= rc_mode_in;
         rc_sync_reg  <= rc_meta_reg;
      end
   end

   // Master clear holds the core at its reset values while low
   assign core_clear = !clr_sync_reg;

   ////////////////////////////////////////////////////////////////////////
   // Phase generator

   qps_pkg::qps_phase_t       phase_reg;
   qps_pkg::qps_phase_t       phase_next;
   logic [3:0]                phase_oh_reg;
   logic [3:0]                phase_oh_next;
   logic                      cyc_clk_reg;
   logic                      cyc_clk_next;

   always_comb begin
      if (core_clear) begin
         // Parked in phase_d so the first edge after release enters a
         phase_next = qps_pkg::QPS_PH_D;
      end else begin
         case (phase_reg)
            qps_pkg::QPS_PH_A: phase_next = qps_pkg::QPS_PH_B;
            qps_pkg::QPS_PH_B: phase_next = qps_pkg::QPS_PH_C;
            qps_pkg::QPS_PH_C: phase_next = qps_pkg::QPS_PH_D;
            qps_pkg::QPS_PH_D: phase_next = qps_pkg::QPS_PH_A;
            default:           phase_next = qps_pkg::QPS_PH_A;
         endcase
      end
      phase_oh_next = 4'h0;
      if (!core_clear) begin
         phase_oh_next[phase_next] = 1'b1;
      end
      // High in a and b, low in c and d: one period per cycle
      cyc_clk_next = rc_sync_reg && !core_clear &&
                     (phase_next == qps_pkg::QPS_PH_A ||
                      phase_next == qps_pkg::QPS_PH_B);
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_reg    <= qps_pkg::QPS_PH_D;
         phase_oh_reg <= 4'h0;
         cyc_clk_reg  <= 1'b0;
      end else begin
         phase_reg    <= phase_next;
         phase_oh_reg <= phase_oh_next;
         cyc_clk_reg  <= cyc_clk_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch stage, execute stage and branch control

   qps_stack_if               stk ();

   logic [`QPS_PC_W-1:0]      pc_reg;
   logic [`QPS_PC_W-1:0]      pc_next;
   logic [`QPS_PC_W-1:0]      fetch_addr_reg;
   logic [`QPS_PC_W-1:0]      fetch_addr_next;
   logic                      prog_rd_reg;
   logic                      prog_rd_next;
   logic [`QPS_INSTR_W-1:0]   fetch_word_reg;
   logic [`QPS_INSTR_W-1:0]   fetch_word_next;
   logic [`QPS_INSTR_W-1:0]   ilatch_reg;
   logic [`QPS_INSTR_W-1:0]   ilatch_next;
   logic                      valid_reg;
   logic                      valid_next;
   logic                      flush_reg;
   logic                      flush_next;
   logic                      push_c;
   logic                      pop_c;

   always_comb begin
      pc_next         = pc_reg;
      fetch_addr_next = fetch_addr_reg;
      prog_rd_next    = 1'b0;
      fetch_word_next = fetch_word_reg;
      ilatch_next     = ilatch_reg;
      valid_next      = valid_reg;
      flush_next      = flush_reg;
      push_c          = 1'b0;
      pop_c           = 1'b0;
      if (core_clear) begin
         pc_next         = `QPS_PC_RESET;
         fetch_addr_next = `QPS_PC_RESET;
         fetch_word_next = `QPS_NOP_WORD;
         ilatch_next     = `QPS_NOP_WORD;
         valid_next      = 1'b0;
         flush_next      = 1'b1;
      end else begin
         case (phase_next)
            qps_pkg::QPS_PH_A: begin
               // Fetch of the next word starts as this one executes
               fetch_addr_next = pc_reg;
               prog_rd_next    = 1'b1;
               pc_next         = pc_reg + `QPS_PC_W'(1);
               if (flush_reg) begin
                  ilatch_next = `QPS_NOP_WORD;
                  valid_next  = 1'b0;
               end else begin
                  ilatch_next = fetch_word_reg;
                  valid_next  = 1'b1;
               end
               flush_next = 1'b0;
            end
            qps_pkg::QPS_PH_D: begin
               fetch_word_next = prog_data_in;
               // Branch requests of a flushed slot are ignored
               if (valid_reg) begin
                  if (exec_return_in) begin
                     pop_c      = 1'b1;
                     pc_next    = stk.top_addr;
                     flush_next = 1'b1;
                  end else if (exec_call_in) begin
                     push_c     = 1'b1;
                     pc_next    = exec_target_in;
                     flush_next = 1'b1;
                  end else if (exec_jump_in) begin
                     pc_next    = exec_target_in;
                     flush_next = 1'b1;
                  end
               end
            end
            default: begin
               prog_rd_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pc_reg         <= `QPS_PC_RESET;
         fetch_addr_reg <= `QPS_PC_RESET;
         prog_rd_reg    <= 1'b0;
         fetch_word_reg <= `QPS_NOP_WORD;
         ilatch_reg     <= `QPS_NOP_WORD;
         valid_reg      <= 1'b0;
         flush_reg      <= 1'b1;
      end else begin
         pc_reg         <= pc_next;
         fetch_addr_reg <= fetch_addr_next;
         prog_rd_reg    <= prog_rd_next;
         fetch_word_reg <= fetch_word_next;
         ilatch_reg     <= ilatch_next;
         valid_reg      <= valid_next;
         flush_reg      <= flush_next;
      end
   end

   // Return address is the word fetched behind the branch
   assign stk.push      = push_c;
   assign stk.pop       = pop_c;
   assign stk.push_addr = fetch_addr_reg;

   qps_stack #(
      .DEPTH  (`QPS_STACK_DEPTH),
      .PTR_W  (`QPS_STACK_PTR_W),
      .ADDR_W (`QPS_PC_W)
   ) u_stack (
      .clk_in    (mclk_in),
      .resetn_in (resetn_in),
      .clear_in  (core_clear),
      .stk       (stk.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // Data memory strobes

   logic [DADDR_W-1:0]        daddr_reg;
   logic [DADDR_W-1:0]        daddr_next;
   logic                      drd_reg;
   logic                      drd_next;
   logic                      dwr_reg;
   logic                      dwr_next;
   logic [`QPS_DATA_W-1:0]    dwdata_reg;
   logic [`QPS_DATA_W-1:0]    dwdata_next;
   logic [`QPS_DATA_W-1:0]    operand_reg;
   logic [`QPS_DATA_W-1:0]    operand_next;

   always_comb begin
      daddr_next   = daddr_reg;
      drd_next     = 1'b0;
      dwr_next     = 1'b0;
      dwdata_next  = dwdata_reg;
      operand_next = operand_reg;
      if (core_clear) begin
         daddr_next   = '0;
         dwdata_next  = `QPS_DATA_RESET;
         operand_next = `QPS_DATA_RESET;
      end else begin
         case (phase_next)
            qps_pkg::QPS_PH_B: begin
               daddr_next = exec_addr_in;
               drd_next   = valid_reg && exec_rd_in;
            end
            qps_pkg::QPS_PH_C: begin
               // Operand is taken at the close of phase_b
               if (drd_reg) begin
                  operand_next = data_rdata_in;
               end
            end
            qps_pkg::QPS_PH_D: begin
               daddr_next  = exec_addr_in;
               dwdata_next = exec_wdata_in;
               dwr_next    = valid_reg && exec_wr_in;
            end
            default: begin
               drd_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         daddr_reg   <= '0;
         drd_reg     <= 1'b0;
         dwr_reg     <= 1'b0;
         dwdata_reg  <= `QPS_DATA_RESET;
         operand_reg <= `QPS_DATA_RESET;
      end else begin
         daddr_reg   <= daddr_next;
         drd_reg     <= drd_next;
         dwr_reg     <= dwr_next;
         dwdata_reg  <= dwdata_next;
         operand_reg <= operand_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign phase_a_out           = phase_oh_reg[qps_pkg::QPS_PH_A];
   assign phase_b_out           = phase_oh_reg[qps_pkg::QPS_PH_B];
   assign phase_c_out           = phase_oh_reg[qps_pkg::QPS_PH_C];
   assign phase_d_out           = phase_oh_reg[qps_pkg::QPS_PH_D];
   assign cycle_clock_out       = cyc_clk_reg;
   assign prog_addr_out         = fetch_addr_reg;
   assign prog_rd_out           = prog_rd_reg;
   assign instruction_latch_out = ilatch_reg;
   assign exec_valid_out        = valid_reg;
   assign data_addr_out         = daddr_reg;
   assign data_rd_out           = drd_reg;
   assign data_wr_out           = dwr_reg;
   assign data_wdata_out        = dwdata_reg;
   assign operand_out           = operand_reg;

endmodule

`default_nettype wire

// *** hw/qps_defs.svh ***
// Constants of the quad-phase fetch/execute sequencer
`ifndef QPS_DEFS_SVH
`define QPS_DEFS_SVH

`define QPS_PC_W          13
`define QPS_INSTR_W       14
`define QPS_DATA_W        8
`define QPS_DADDR_W       9
`define QPS_STACK_DEPTH   8
`define QPS_STACK_PTR_W   3
`define QPS_PHASE_COUNT   4
`define QPS_PC_RESET      13'h0000
`define QPS_NOP_WORD      14'h0000
`define QPS_DATA_RESET    8'h00

`endif

// *** hw/qps_pkg.sv ***
// Types used by the sequencer phase generator
package qps_pkg;

   typedef enum logic [1:0] {
      QPS_PH_A = 2'b00,
      QPS_PH_B = 2'b01,
      QPS_PH_C = 2'b10,
      QPS_PH_D = 2'b11
   } qps_phase_t;

endpackage

// *** hw/qps_stack_if.sv ***
// Link between the sequencer core and its return-address stack
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

interface qps_stack_if;
   logic                   push;
   logic                   pop;
   logic [`QPS_PC_W-1:0]   push_addr;
   logic [`QPS_PC_W-1:0]   top_addr;

   modport core (
      output push,
      output pop,
      output push_addr,
      input  top_addr
   );

   modport mem (
      input  push,
      input  pop,
      input  push_addr,
      output top_addr
   );
endinterface

`default_nettype wire

// *** hw/qps_stack.sv ***
// Circular return-address stack with registered top-of-stack read
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

module qps_stack #(
   parameter int DEPTH = `QPS_STACK_DEPTH,
   parameter int PTR_W = `QPS_STACK_PTR_W,
   parameter int ADDR_W = `QPS_PC_W
) (
   input  wire logic   clk_in,
   input  wire logic   resetn_in,
   input  wire logic   clear_in,
   qps_stack_if.mem    stk
);

   logic [ADDR_W-1:0]  mem_reg [DEPTH];
   logic [ADDR_W-1:0]  mem_next [DEPTH];
   logic [PTR_W-1:0]   ptr_reg;
   logic [PTR_W-1:0]   ptr_next;
   logic [ADDR_W-1:0]  top_reg;
   logic [ADDR_W-1:0]  top_next;

   ////////////////////////////////////////////////////////////////////////
   // Pointer wraps freely: no overflow or underflow is flagged
   always_comb begin
      mem_next = mem_reg;
      ptr_next = ptr_reg;
      if (clear_in) begin
         ptr_next = '0;
      end else if (stk.push) begin
         mem_next[ptr_reg] = stk.push_addr;
         ptr_next = ptr_reg + PTR_W'(1);
      end else if (stk.pop) begin
         ptr_next = ptr_reg - PTR_W'(1);
      end
      // Top lags a push by one edge; pops come four edges apart at least
      top_next = mem_reg[ptr_reg - PTR_W'(1)];
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         ptr_reg <= '0;
         top_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         ptr_reg <= ptr_next;
         top_reg <= top_next;
      end
   end

   assign stk.top_addr = top_reg;

endmodule

`default_nettype wire

// *** dv/qps_mem_model.sv ***
// Program and data memory model facing the sequencer core
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

module qps_mem_model #(
   parameter int DADDR_W = `QPS_DADDR_W
) (
   input  wire logic                    mclk_in,
   input  wire logic [`QPS_PC_W-1:0]    prog_addr_in,
   output logic [`QPS_INSTR_W-1:0]      prog_data_out,
   input  wire logic [DADDR_W-1:0]      data_addr_in,
   input  wire logic                    data_rd_in,
   input  wire logic                    data_wr_in,
   input  wire logic [`QPS_DATA_W-1:0]  data_wdata_in,
   output logic [`QPS_DATA_W-1:0]       data_rdata_out
);
   logic [`QPS_DATA_W-1:0] mem [2**DADDR_W];
   logic [`QPS_DATA_W-1:0] idle_reg;
////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 2**DADDR_W; i++) mem[i] = 8'(i) ^ 8'h5a;
      idle_reg = 8'h33;
   end
   // Word carries its own address so the bench can predict it
   assign prog_data_out = {1'b1, prog_addr_in};
   // Idle bus churns: a stale value must never look like a read
   assign data_rdata_out = data_rd_in ? mem[data_addr_in] : idle_reg;
   always @(posedge mclk_in) begin
      idle_reg <= ~idle_reg;
      if (data_wr_in) mem[data_addr_in] <= data_wdata_in;
   end
endmodule
`default_nettype wire

// *** dv/qps_seq_chk.sv ***
// Timing checker bound to the sequencer top ports
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

module qps_seq_chk #(
   parameter int DADDR_W = `QPS_DADDR_W
) (
   input wire logic               mclk_in,
   input wire logic               resetn_in,
   input wire logic               master_clear_n_in,
   input wire logic               rc_mode_in,
   input wire logic               phase_a_out,
   input wire logic               phase_b_out,
   input wire logic               phase_c_out,
   input wire logic               phase_d_out,
   input wire logic               cycle_clock_out,
   input wire logic [12:0]        prog_addr_out,
   input wire logic               prog_rd_out,
   input wire logic [13:0]        prog_data_in,
   input wire logic [13:0]        instruction_latch_out,
   input wire logic               exec_valid_out,
   input wire logic               exec_jump_in,
   input wire logic               exec_call_in,
   input wire logic               exec_return_in,
   input wire logic [12:0]        exec_target_in,
   input wire logic               exec_rd_in,
   input wire logic               exec_wr_in,
   input wire logic [DADDR_W-1:0] exec_addr_in,
   input wire logic [7:0]         exec_wdata_in,
   input wire logic [DADDR_W-1:0] data_addr_out,
   input wire logic               data_rd_out,
   input wire logic               data_wr_out,
   input wire logic [7:0]         data_wdata_out,
   input wire logic [7:0]         data_rdata_in,
   input wire logic [7:0]         operand_out
);
   default clocking cb @(posedge mclk_in); endclocking
   // Clear pin is synced late, so its whole low span is excluded
   default disable iff (!resetn_in || !master_clear_n_in);
////////////////////////////////////////////////////////////////////////
   sequence s_cycle;
      phase_a_out ##1 phase_b_out ##1 phase_c_out ##1 phase_d_out;
   endsequence
   sequence s_nop_then_target;
      (phase_a_out && !exec_valid_out
       && instruction_latch_out == `QPS_NOP_WORD)
      ##4 (phase_a_out && exec_valid_out);
   endsequence

   a_phase_order: assert property (phase_a_out |-> s_cycle ##1 phase_a_out)
      else $error("phase order broken");
   a_fetch_strobe: assert property (prog_rd_out == phase_a_out)
      else $error("fetch strobe outside phase a");
   a_pc_step: assert property (phase_a_out && exec_valid_out |->
      prog_addr_out == $past(prog_addr_out, 4) + 13'h0001)
      else $error("fetch address not sequential");
   a_word_capture: assert property (phase_a_out && exec_valid_out |->
      instruction_latch_out == $past(prog_data_in, 2))
      else $error("latched word differs from fetched word");
   a_latch_hold: assert property (!phase_a_out |->
      $stable(instruction_latch_out) && $stable(prog_addr_out))
      else $error("latch or address moved outside phase a");
   a_branch_flush: assert property (phase_c_out && exec_valid_out
      && (exec_jump_in || exec_call_in) && !exec_return_in
      |-> ##2 prog_addr_out == $past(exec_target_in, 2) ##0 s_nop_then_target)
      else $error("branch not taken as flush plus target");
   a_data_read: assert property (phase_a_out && exec_valid_out && exec_rd_in
      |=> (data_rd_out && phase_b_out && data_addr_out == $past(exec_addr_in))
      ##1 operand_out == $past(data_rdata_in))
      else $error("operand read wrong");
   a_data_write: assert property (phase_c_out && exec_valid_out && exec_wr_in
      |=> data_wr_out && data_addr_out == $past(exec_addr_in)
      && data_wdata_out == $past(exec_wdata_in))
      else $error("destination write wrong");
   a_nop_quiet: assert property (phase_a_out && !exec_valid_out
      |=> !data_rd_out ##2 !data_wr_out)
      else $error("flushed cycle touched data memory");
   a_rc_clock_on: assert property (rc_mode_in [*5] |->
      cycle_clock_out == (phase_a_out || phase_b_out))
      else $error("cycle clock wrong in rc mode");
   a_rc_clock_off: assert property (!rc_mode_in [*5] |-> !cycle_clock_out)
      else $error("cycle clock active outside rc mode");
   a_clear_start: assert property ($rose(phase_a_out) && !$past(phase_d_out)
      |-> prog_addr_out == `QPS_PC_RESET && !exec_valid_out)
      else $error("restart not at address zero");
endmodule

bind qps_sequencer qps_seq_chk #(.DADDR_W(DADDR_W)) u_qps_seq_chk (.*);
`default_nettype wire

// *** dv/quad_phase_fetch_execute_sequencer_tb_top.sv ***
// Self-checking bench for the quad-phase fetch/execute sequencer
`timescale 1ns/100ps
`default_nettype none
`include "qps_defs.svh"

module quad_phase_fetch_execute_sequencer_tb_top;
   logic        mclk_in, resetn_in, master_clear_n_in, rc_mode_in;
   logic        phase_a_out, phase_b_out, phase_c_out, phase_d_out;
   logic        cycle_clock_out, prog_rd_out, exec_valid_out;
   logic        exec_jump_in, exec_call_in, exec_return_in;
   logic        exec_rd_in, exec_wr_in, data_rd_out, data_wr_out;
   logic [12:0] prog_addr_out, exec_target_in, cur_fa, br_tgt;
   logic [13:0] prog_data_in, instruction_latch_out;
   logic [8:0]  exec_addr_in, data_addr_out, op_addr;
   logic [7:0]  exec_wdata_in, data_wdata_out, data_rdata_in, operand_out;
   logic [27:0] exp_ex[$];
   logic [16:0] exp_rd[$], exp_wr[$], op_exp;
   logic [7:0]  shadow[512];
   logic [12:0] stk[8];
   logic [2:0]  sp;
   logic [31:0] r;
   logic [1:0]  br;
   logic        cur_valid, br_pend, op_due;
   int          seed = 29;
   int          depth, compares = 0, miscompares = 0;

   qps_sequencer u_qps_sequencer (.*);
   qps_mem_model u_qps_mem_model (
      .mclk_in        (mclk_in),
      .prog_addr_in   (prog_addr_out),
      .prog_data_out  (prog_data_in),
      .data_addr_in   (data_addr_out),
      .data_rd_in     (data_rd_out),
      .data_wr_in     (data_wr_out),
      .data_wdata_in  (data_wdata_out),
      .data_rdata_out (data_rdata_in)
   );
////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   task automatic fail(input string what);
      miscompares++;
      $display("unexpected %0t: %s", $time, what);
   endtask
   task automatic cmp_ex(input logic [27:0] got, input logic [27:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("exec %h not %h", got, exp));
   endtask
   task automatic cmp_rd(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("read %h not %h", got, exp));
   endtask
   task automatic cmp_wr(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("write %h not %h", got, exp));
   endtask

   task automatic stop_test;
      if (exp_ex.size() + exp_rd.size() + exp_wr.size() != 0) fail("left over");
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Cycle after clear is always a flushed fetch of address zero
   task automatic start;
      sp = 3'd0;
      depth = 0;
      br_pend = 1'b0;
      cur_fa = `QPS_PC_RESET;
      op_due = 1'b0;
      exp_ex.delete();
      exp_rd.delete();
      exp_wr.delete();
      @(posedge mclk_in iff phase_a_out === 1'b1);
      exp_ex.push_back({1'b0, `QPS_NOP_WORD, `QPS_PC_RESET});
   endtask

   // One instruction cycle: read request in a, the rest in b and c
   task automatic cyc(input logic rd, input logic wr, input logic [1:0] b,
                      input logic [12:0] tgt);
      logic [8:0]  ra;
      logic [8:0]  wa;
      logic [7:0]  wd;
      logic [12:0] pf;
      ra = 9'($random(seed));
      wa = 9'($random(seed));
      wd = 8'($random(seed));
      @(posedge mclk_in iff phase_d_out === 1'b1);
      exec_rd_in <= rd;
      exec_addr_in <= ra;
      pf = cur_fa;
      cur_fa = br_pend ? br_tgt : pf + 13'h0001;
      cur_valid = !br_pend;
      br_pend = 1'b0;
      exp_ex.push_back({cur_valid, cur_valid ? {1'b1, pf} : 14'h0, cur_fa});
      if (cur_valid) begin
         if (rd) exp_rd.push_back({ra, shadow[ra]});
         if (wr) exp_wr.push_back({wa, wd});
         if (wr) shadow[wa] = wd;
         br_pend = (b != 2'd0);
         br_tgt = tgt;
         if (b == 2'd2) begin
            stk[sp] = cur_fa;
            sp = sp + 3'd1;
            depth++;
         end
         if (b == 2'd3) begin
            sp = sp - 3'd1;
            br_tgt = stk[sp];
            depth--;
         end
      end
      @(posedge mclk_in);
      exec_rd_in <= 1'b0;
      exec_addr_in <= wa;
      exec_wr_in <= wr;
      exec_wdata_in <= wd;
      exec_jump_in <= (b == 2'd1);
      exec_call_in <= (b == 2'd2);
      exec_return_in <= (b == 2'd3);
      exec_target_in <= tgt;
      repeat (2) @(posedge mclk_in);
      exec_wr_in <= 1'b0;
      exec_jump_in <= 1'b0;
      exec_call_in <= 1'b0;
      exec_return_in <= 1'b0;
   endtask

   always @(posedge mclk_in) begin
      if (phase_b_out === 1'b1 && exp_ex.size() == 0) fail("stray exec");
      else if (phase_b_out === 1'b1)
         cmp_ex({exec_valid_out, instruction_latch_out, prog_addr_out},
                exp_ex.pop_front());
      if (op_due) cmp_rd({op_addr, operand_out}, op_exp);
      op_due = 1'b0;
      if (data_rd_out === 1'b1 && exp_rd.size() == 0) fail("stray read");
      else if (data_rd_out === 1'b1) begin
         op_due = 1'b1;
         op_addr = data_addr_out;
         op_exp = exp_rd.pop_front();
      end
      if (data_wr_out === 1'b1 && exp_wr.size() == 0) fail("stray write");
      else if (data_wr_out === 1'b1)
         cmp_wr({data_addr_out, data_wdata_out}, exp_wr.pop_front());
   end

   initial begin
      repeat (5000) @(posedge mclk_in);
      fail("watchdog expired");
      stop_test();
   end

   initial begin
      resetn_in = 1'b0;
      master_clear_n_in = 1'b1;
      rc_mode_in = 1'b1;
      {exec_jump_in, exec_call_in, exec_return_in} = 3'h0;
      {exec_rd_in, exec_wr_in} = 2'h0;
      exec_target_in = 13'h0000;
      exec_addr_in = 9'h000;
      exec_wdata_in = 8'h00;
      for (int i = 0; i < 512; i++) shadow[i] = 8'(i) ^ 8'h5a;
      repeat (10) @(posedge mclk_in);
      resetn_in <= 1'b1;
      start();
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         br = r[4] ? 2'd0 : r[1:0];
         if (br == 2'd3 && depth <= 0) br = 2'd0;
         if (i == 40) rc_mode_in <= 1'b0;
         if (i == 60) rc_mode_in <= 1'b1;
         cyc(r[2], r[3], br, 13'(r >> 8));
      end
      // Calls every cycle: the flushed ones must be ignored
      for (int i = 0; i < 18; i++) cyc(1'b0, 1'b1, 2'd2, 13'h0100 + 13'(i));
      for (int i = 0; i < 18; i++) cyc(1'b1, 1'b0, 2'd3, 13'h0000);
      // Clear must be seen before the next phase_b, or that phase_b is reported as a stray exec
      fork
         cyc(1'b0, 1'b0, 2'd0, 13'h0000);
         begin
            @(posedge mclk_in iff phase_b_out === 1'b1);
            master_clear_n_in <= 1'b0;
         end
      join
      repeat (8) @(posedge mclk_in);
      master_clear_n_in <= 1'b1;
      start();
      for (int i = 0; i < 8; i++) cyc(1'b1, 1'b1, 2'd0, 13'h0000);
      // Let the last phase_d write reach the monitor, stop before phase_b
      repeat (2) @(posedge mclk_in);
      stop_test();
   end
endmodule
`default_nettype wire
